// >>> pkg/psi_params.svh
// Purpose: Named constants of the supply's two-wire slave interface
// Assumes: 20 MHz system clock
// Notes:   Cycle counts derive from the printed times
`ifndef PSI_PARAMS_SVH
`define PSI_PARAMS_SVH

`define PSI_CLK_MHZ        20
`define PSI_STRETCH_MAX_US 1000
`define PSI_STRETCH_CYC    (`PSI_STRETCH_MAX_US * `PSI_CLK_MHZ)
`define PSI_SCL_TMO_US     25000
`define PSI_SCL_TMO_CYC    (`PSI_SCL_TMO_US * `PSI_CLK_MHZ)
`define PSI_CTL_BASE       7'h58
`define PSI_CTL_OPEN       7'h5b
`define PSI_EEP_OFS        7'h08
`define PSI_ARA_BYTE       8'h19
`define PSI_STRAP_OPEN     4'h8
`define PSI_STRAP_REG_BIT  2
`define PSI_STRAP_DLY      2'h3
`define PSI_REG_WR_LEN     8'h03
`define PSI_REG_RD_LEN     8'h02
`define PSI_BLK_MAX        9'h0ff
`define PSI_IDX_MAX        9'h1ff
`define PSI_BIT_FULL       4'h8
`define PSI_IDLE_BYTE      8'hff
`define PSI_MEM_AW         8
`define PSI_MEM_DEPTH      256
`define PSI_SYNC_W         6

`endif

// >>> pkg/psi_pkg.sv
// Purpose: Types of the supply's two-wire slave interface
// Assumes: Nothing
// Notes:   States are Gray coded in declaration order
package psi_pkg;

	typedef enum logic [2:0] {
		PSI_IDLE   = 3'h0,
		PSI_RX     = 3'h1,
		PSI_RX_ACK = 3'h3,
		PSI_WAIT   = 3'h2,
		PSI_TX     = 3'h6,
		PSI_TX_ACK = 3'h7,
		PSI_SKIP   = 3'h5
	} psi_state_e;

	typedef enum logic [1:0] {
		PSI_TGT_NONE = 2'h0,
		PSI_TGT_CTL  = 2'h1,
		PSI_TGT_EEP  = 2'h2,
		PSI_TGT_ARA  = 2'h3
	} psi_tgt_e;

endpackage

// >>> logic/psi_sync.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs asynchronous to clk
// Notes:   Only the second stage is visible outside
`timescale 1ns/1ps
module psi_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_r;

	genvar gi;
	generate
		for (gi = 0; gi < W; gi++)
		begin : g_bit
			always_ff @(posedge clk or negedge reset_n)
			begin
				if (!reset_n)
				begin
					meta_r[gi]   <= 1'b1;
					sync_out[gi] <= 1'b1;
				end
				else
				begin
					meta_r[gi]   <= async_in[gi];
					sync_out[gi] <= meta_r[gi];
				end
			end
		end
	endgenerate

endmodule

// >>> logic/psi_eeprom_mem.sv
// Purpose: User byte store behind the EEPROM address
// Assumes: One write or one read per cycle
// Notes:   Read data leave through a register
`timescale 1ns/1ps
`include "psi_params.svh"
module psi_eeprom_mem (
	input  wire logic                   clk,
	input  wire logic                   we,
	input  wire logic [`PSI_MEM_AW-1:0] waddr,
	input  wire logic [7:0]             wdata,
	input  wire logic                   re,
	input  wire logic [`PSI_MEM_AW-1:0] raddr,
	output logic      [7:0]             rdata
);

	logic [7:0] mem [`PSI_MEM_DEPTH];

	always_ff @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
		if (re)
			rdata <= mem[raddr];
	end

endmodule

// >>> logic/psi_slave.sv
// Purpose: Slave-only two-wire interface of the supply's controller and EEPROM
// Assumes: 20 MHz clk, host clocks the bus at 100 kbps or less
// Notes:   Pins are open drain, output enable high pulls the line low
`timescale 1ns/1ps
`include "psi_params.svh"
// Behaviour
// - Slave only, never starts a transfer
// - Clock stretch released within 1 ms
// - SCL low over 25 ms returns to idle
// - START or STOP recognised at any time
// - Works at bus rates up to 100 kbps
// - Alert low on shutdown OR warning
// - Alert response address returns the status word
// - Eight strap codes pick protocol and address
// - Open strap gives register mode, 0xB6/0xA6
// - Strap sampled once after reset only
// - EEPROM address fixed offset below controller
// - Address in upper seven bits, direction LSB
// - EEPROM writes blocked until protection lifted
// - EEPROM holds 256 user bytes untouched
// - EEPROM write: address, location, data, STOP
// - EEPROM read via location then repeated START
// - Register mode has one format, no PEC
// - Register mode writes exactly 16 bits
// - Register mode reads exactly 16 bits
// - Bus mode writes end after 1-255 bytes
// - Bus mode accepts block writes to 255 bytes
// - Bus mode answers block reads to 255 bytes
module psi_slave
	import psi_pkg::*;
#(
	parameter int STRETCH_CYC = `PSI_STRETCH_CYC,
	parameter int TMO_CYC     = `PSI_SCL_TMO_CYC
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic [3:0]  addr_protocol_strap,
	input  wire logic        shutdown_evt,
	input  wire logic        warning_evt,
	input  wire logic [15:0] status_word,
	input  wire logic        eeprom_wp_off,
	input  wire logic        ctl_rd_valid,
	input  wire logic [7:0]  ctl_rd_data,
	output logic             alert_out_n,
	output logic             ctl_rx_valid,
	output logic [7:0]       ctl_rx_byte,
	output logic [7:0]       ctl_rx_index,
	output logic             ctl_wr_done,
	output logic [7:0]       ctl_wr_len,
	output logic             ctl_rd_req,
	output logic [7:0]       ctl_rd_index,
	output logic             proto_reg_mode,
	output logic [6:0]       ctl_addr
);

	localparam logic [14:0] STR_LIM = 15'(STRETCH_CYC);
	localparam logic [19:0] TMO_LIM = 20'(TMO_CYC);

	logic [5:0]  sync_q;
	logic        scl_s;
	logic        sda_s;
	logic [3:0]  strap_s;
	logic        scl_q;
	logic        sda_q;
	psi_state_e  state_r;
	psi_tgt_e    tgt_r;
	psi_tgt_e    tgt_c;
	logic        rw_r;
	logic [3:0]  bit_r;
	logic [7:0]  sh_r;
	logic [8:0]  idx_r;
	logic [7:0]  rd_idx;
	logic        sda_oe_r;
	logic        scl_oe_r;
	logic [19:0] low_cnt_r;
	logic [14:0] str_cnt_r;
	logic        reg_mode_r;
	logic [6:0]  ctl_addr_r;
	logic [6:0]  eep_addr;
	logic [1:0]  strap_cnt_r;
	logic        strap_taken_r;
	logic        alert_n_r;
	logic [7:0]  eptr_r;
	logic        mem_vld_r;
	logic [7:0]  mem_rdata;
	logic        mem_we;
	logic        rx_vld_r;
	logic [7:0]  rx_byte_r;
	logic [7:0]  rx_idx_r;
	logic        wr_done_r;
	logic [7:0]  wr_len_r;
	logic        rd_req_r;
	logic [7:0]  rd_idx_r;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_det;
	logic        stop_det;
	logic        tmo;
	logic        ev_ok;
	logic        rx_done;
	logic        go_wait;
	logic        ack_c;
	logic        tx_rdy;
	logic [7:0]  tx_byte;

	function automatic logic [7:0] psi_strap_dec(input logic [3:0] code);
		if (code >= `PSI_STRAP_OPEN)
			return {1'b1, `PSI_CTL_OPEN};
		return {code[`PSI_STRAP_REG_BIT], 7'(`PSI_CTL_BASE + {5'h00, code[1:0]})};
	endfunction

	psi_sync #(
		.W (`PSI_SYNC_W)
	) u_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.async_in ({addr_protocol_strap, sda_in, scl_in}),
		.sync_out (sync_q)
	);
	assign scl_s   = sync_q[0];
	assign sda_s   = sync_q[1];
	assign strap_s = sync_q[5:2];

	// Edges on synchronised pins; bus at 100 kbps leaves >90 clocks per SCL phase
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	assign scl_rise  = scl_s & ~scl_q;
	assign scl_fall  = ~scl_s & scl_q;
	assign start_det = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;
	assign tmo       = (low_cnt_r == TMO_LIM);
	assign ev_ok     = ~tmo & ~start_det & ~stop_det;
	assign rx_done   = ev_ok && state_r == PSI_RX && scl_fall && bit_r == `PSI_BIT_FULL;
	assign go_wait   = ev_ok && scl_fall && (state_r == PSI_RX_ACK && rw_r
		|| state_r == PSI_TX_ACK);
	assign rd_idx    = 8'(idx_r - 9'h001);
	assign eep_addr  = 7'(ctl_addr_r - `PSI_EEP_OFS);

	// SCL low time watch
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			low_cnt_r <= '0;
		else if (scl_s)
			low_cnt_r <= '0;
		else if (!tmo)
			low_cnt_r <= low_cnt_r + 20'h00001;
	end

	// Stretch length watch
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			str_cnt_r <= '0;
		else if (state_r != PSI_WAIT)
			str_cnt_r <= '0;
		else
			str_cnt_r <= str_cnt_r + 15'h0001;
	end

	// Strap taken once, a few clocks after reset release
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			strap_cnt_r   <= '0;
			strap_taken_r <= 1'b0;
			reg_mode_r    <= 1'b1;
			ctl_addr_r    <= `PSI_CTL_OPEN;
		end
		else if (!strap_taken_r)
		begin
			strap_cnt_r <= strap_cnt_r + 2'h1;
			if (strap_cnt_r == `PSI_STRAP_DLY)
			begin
				strap_taken_r             <= 1'b1;
				{reg_mode_r, ctl_addr_r} <= psi_strap_dec(strap_s);
			end
		end
	end

	// Alert pin
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			alert_n_r <= 1'b1;
		else
			alert_n_r <= ~(shutdown_evt | warning_evt);
	end

	// Address match and acknowledge decision
	always_comb
	begin
		tgt_c = PSI_TGT_NONE;
		ack_c = 1'b0;
		if (idx_r == 9'h000)
		begin
			if (sh_r == `PSI_ARA_BYTE)
				tgt_c = PSI_TGT_ARA;
			else if (sh_r[7:1] == ctl_addr_r)
				tgt_c = PSI_TGT_CTL;
			else if (sh_r[7:1] == eep_addr)
				tgt_c = PSI_TGT_EEP;
			ack_c = strap_taken_r && tgt_c != PSI_TGT_NONE;
		end
		else
		begin
			tgt_c = tgt_r;
			case (tgt_r)
				PSI_TGT_CTL: ack_c = reg_mode_r ? idx_r <= 9'(`PSI_REG_WR_LEN)
					: idx_r <= `PSI_BLK_MAX;
				PSI_TGT_EEP: ack_c = 1'b1;
				default:     ack_c = 1'b0;
			endcase
		end
	end

	// Byte to send and whether it is ready
	always_comb
	begin
		tx_byte = `PSI_IDLE_BYTE;
		tx_rdy  = 1'b1;
		case (tgt_r)
			PSI_TGT_CTL:
			begin
				if (!reg_mode_r || rd_idx < `PSI_REG_RD_LEN)
				begin
					tx_rdy  = ctl_rd_valid || str_cnt_r >= STR_LIM - 15'h0001;
					tx_byte = ctl_rd_valid ? ctl_rd_data : `PSI_IDLE_BYTE;
				end
			end
			PSI_TGT_EEP:
			begin
				tx_rdy  = mem_vld_r;
				tx_byte = mem_rdata;
			end
			PSI_TGT_ARA:
			begin
				if (rd_idx == 8'h00)
					tx_byte = status_word[7:0];
				else if (rd_idx == 8'h01)
					tx_byte = status_word[15:8];
			end
			default:
			begin
				tx_byte = `PSI_IDLE_BYTE;
			end
		endcase
	end

	// Bit and byte sequencer; lines only ever pulled low in answer to the host
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_r  <= PSI_IDLE;
			tgt_r    <= PSI_TGT_NONE;
			rw_r     <= 1'b0;
			bit_r    <= '0;
			sh_r     <= '0;
			idx_r    <= '0;
			sda_oe_r <= 1'b0;
			scl_oe_r <= 1'b0;
		end
		else if (tmo)
		begin
			state_r  <= PSI_IDLE;
			sda_oe_r <= 1'b0;
			scl_oe_r <= 1'b0;
		end
		else if (start_det)
		begin
			state_r  <= PSI_RX;
			tgt_r    <= PSI_TGT_NONE;
			bit_r    <= '0;
			idx_r    <= '0;
			sda_oe_r <= 1'b0;
			scl_oe_r <= 1'b0;
		end
		else if (stop_det)
		begin
			state_r  <= PSI_IDLE;
			sda_oe_r <= 1'b0;
			scl_oe_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				PSI_RX:
				begin
					if (scl_rise)
					begin
						sh_r  <= {sh_r[6:0], sda_s};
						bit_r <= bit_r + 4'h1;
					end
					else if (rx_done)
					begin
						bit_r    <= '0;
						sda_oe_r <= ack_c;
						state_r  <= ack_c ? PSI_RX_ACK : PSI_SKIP;
						tgt_r    <= tgt_c;
						if (idx_r == 9'h000)
							rw_r <= sh_r[0];
						if (idx_r != `PSI_IDX_MAX)
							idx_r <= idx_r + 9'h001;
					end
				end
				PSI_RX_ACK:
				begin
					if (scl_fall)
					begin
						sda_oe_r <= 1'b0;
						scl_oe_r <= rw_r;
						state_r  <= rw_r ? PSI_WAIT : PSI_RX;
					end
				end
				PSI_WAIT:
				begin
					if (tx_rdy)
					begin
						sh_r     <= tx_byte;
						sda_oe_r <= ~tx_byte[7];
						scl_oe_r <= 1'b0;
						bit_r    <= 4'h1;
						state_r  <= PSI_TX;
						if (idx_r != `PSI_IDX_MAX)
							idx_r <= idx_r + 9'h001;
					end
				end
				PSI_TX:
				begin
					if (scl_fall)
					begin
						if (bit_r == `PSI_BIT_FULL)
						begin
							sda_oe_r <= 1'b0;
							state_r  <= PSI_TX_ACK;
						end
						else
						begin
							sda_oe_r <= ~sh_r[6];
							sh_r     <= {sh_r[6:0], 1'b1};
							bit_r    <= bit_r + 4'h1;
						end
					end
				end
				PSI_TX_ACK:
				begin
					if (scl_rise && sda_s)
						state_r <= PSI_SKIP;
					else if (scl_fall)
					begin
						scl_oe_r <= 1'b1;
						state_r  <= PSI_WAIT;
					end
				end
				default:
				begin
					state_r <= state_r;
				end
			endcase
		end
	end

	// EEPROM pointer, write gate and read prefetch
	assign mem_we = rx_done && tgt_r == PSI_TGT_EEP && idx_r >= 9'h002
		&& eeprom_wp_off;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			eptr_r    <= '0;
			mem_vld_r <= 1'b0;
		end
		else
		begin
			mem_vld_r <= go_wait && (tgt_r == PSI_TGT_EEP || state_r == PSI_RX_ACK);
			if (rx_done && tgt_r == PSI_TGT_EEP && idx_r == 9'h001)
				eptr_r <= sh_r;
			else if (rx_done && tgt_r == PSI_TGT_EEP && idx_r >= 9'h002)
				eptr_r <= eptr_r + 8'h01;
			else if (state_r == PSI_WAIT && tx_rdy && tgt_r == PSI_TGT_EEP)
				eptr_r <= eptr_r + 8'h01;
		end
	end

	psi_eeprom_mem u_mem (
		.clk   (clk),
		.we    (mem_we),
		.waddr (eptr_r),
		.wdata (sh_r),
		.re    (go_wait),
		.raddr (eptr_r),
		.rdata (mem_rdata)
	);

	// Controller side strobes
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_vld_r  <= 1'b0;
			rx_byte_r <= '0;
			rx_idx_r  <= '0;
			wr_done_r <= 1'b0;
			wr_len_r  <= '0;
			rd_req_r  <= 1'b0;
			rd_idx_r  <= '0;
		end
		else
		begin
			rx_vld_r  <= rx_done && tgt_r == PSI_TGT_CTL && idx_r != 9'h000 && ack_c;
			rd_req_r  <= go_wait && tgt_r == PSI_TGT_CTL;
			wr_done_r <= stop_det && tgt_r == PSI_TGT_CTL && !rw_r && idx_r >= 9'h002
				&& (!reg_mode_r || rd_idx == `PSI_REG_WR_LEN);
			if (rx_done)
			begin
				rx_byte_r <= sh_r;
				rx_idx_r  <= rd_idx;
			end
			if (stop_det)
				wr_len_r <= rd_idx;
			if (go_wait)
				rd_idx_r <= state_r == PSI_RX_ACK ? 8'h00 : rd_idx;
		end
	end

	// Open-drain drivers only ever pull low
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end
		else
		begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end
	end

	assign scl_oe         = scl_oe_r;
	assign sda_oe         = sda_oe_r;
	assign alert_out_n    = alert_n_r;
	assign ctl_rx_valid   = rx_vld_r;
	assign ctl_rx_byte    = rx_byte_r;
	assign ctl_rx_index   = rx_idx_r;
	assign ctl_wr_done    = wr_done_r;
	assign ctl_wr_len     = wr_len_r;
	assign ctl_rd_req     = rd_req_r;
	assign ctl_rd_index   = rd_idx_r;
	assign proto_reg_mode = reg_mode_r;
	assign ctl_addr       = ctl_addr_r;

	// Checks
	logic [14:0] str_mon_r;
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			str_mon_r <= '0;
		else
			str_mon_r <= scl_oe_r ? str_mon_r + 15'h0001 : 15'h0000;
	end

	a_idle_no_drive: assert property (@(posedge clk) disable iff (!reset_n)
		state_r == PSI_IDLE |=> !scl_oe_r || $past(state_r) != PSI_IDLE)
		else $error("line driven while idle");
	a_stretch_limit: assert property (@(posedge clk) disable iff (!reset_n)
		str_mon_r <= STR_LIM)
		else $error("clock stretch too long");
	a_timeout_idle: assert property (@(posedge clk) disable iff (!reset_n)
		tmo |=> state_r == PSI_IDLE && !scl_oe_r && !sda_oe_r)
		else $error("timeout did not idle");
	a_start_restart: assert property (@(posedge clk) disable iff (!reset_n)
		start_det && !tmo |=> state_r == PSI_RX && bit_r == 4'h0 && idx_r == 9'h000)
		else $error("start not restarting");
	a_stop_idle: assert property (@(posedge clk) disable iff (!reset_n)
		stop_det |=> state_r == PSI_IDLE ##1 !sda_oe_r)
		else $error("stop not idling");
	a_alert_or: assert property (@(posedge clk) disable iff (!reset_n)
		(shutdown_evt || warning_evt) |=> !alert_out_n)
		else $error("alert missing");
	a_alert_clear: assert property (@(posedge clk) disable iff (!reset_n)
		!shutdown_evt && !warning_evt |=> alert_out_n)
		else $error("alert without event");
	a_strap_hold: assert property (@(posedge clk) disable iff (!reset_n)
		strap_taken_r |=> $stable(ctl_addr_r) && $stable(reg_mode_r))
		else $error("strap choice changed");
	a_wp_block: assert property (@(posedge clk) disable iff (!reset_n)
		mem_we |-> eeprom_wp_off && tgt_r == PSI_TGT_EEP)
		else $error("eeprom written while protected");
	a_reg_wr_len: assert property (@(posedge clk) disable iff (!reset_n)
		ctl_wr_done && proto_reg_mode |-> ctl_wr_len == `PSI_REG_WR_LEN)
		else $error("register write not a word");
	a_foreign_nack: assert property (@(posedge clk) disable iff (!reset_n)
		rx_done && idx_r == 9'h000 && tgt_c == PSI_TGT_NONE |=> !sda_oe_r
		&& state_r == PSI_SKIP)
		else $error("foreign address acknowledged");

endmodule

// >>> test/psi_host_model.sv
// Purpose: Bus master model of the host management controller
// Assumes: Open-drain lines with pull-up, resolved by the bench
// Notes:   Bit time 100 clk low and 100 clk high at 20 MHz
`timescale 1ns/1ps
module psi_host_model #(
	parameter int GAP_CYC = 400
) (
	input  wire logic clk,
	input  wire logic scl_w,
	input  wire logic sda_w,
	output logic      scl_lo,
	output logic      sda_lo
);
	initial
	begin
		scl_lo = 1'b0;
		sda_lo = 1'b0;
	end
	task automatic hw(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Release SCL, wait out a stretch of up to 1000 clocks
	task automatic scl_up();
		int k;
		scl_lo = 1'b0;
		hw(1);
		for (k = 0; k < 1000 && !scl_w; k++) hw(1);
	endtask
	task automatic wbit(input logic b);
		sda_lo = !b;
		hw(50);
		scl_up();
		hw(100);
		scl_lo = 1'b1;
		hw(50);
	endtask
	task automatic rbit(output logic b);
		sda_lo = 1'b0;
		hw(50);
		scl_up();
		hw(50);
		b = sda_w;
		hw(50);
		scl_lo = 1'b1;
		hw(50);
	endtask
	task automatic hstart();
		sda_lo = 1'b0;
		hw(50);
		scl_up();
		hw(100);
		sda_lo = 1'b1;
		hw(100);
		scl_lo = 1'b1;
		hw(50);
	endtask
	task automatic hstop(input logic eep_wr);
		sda_lo = 1'b1;
		hw(50);
		scl_up();
		hw(100);
		sda_lo = 1'b0;
		hw(100);
		if (eep_wr)
			hw(GAP_CYC);
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) wbit(d[i]);
		rbit(b);
		ack = !b;
	endtask
	task automatic rbyte(input logic ackit, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) rbit(d[i]);
		wbit(!ackit);
	endtask
endmodule

// >>> test/tb.sv
// Purpose: Self-checking bench of the two-wire slave interface
// Assumes: Shortened stretch and timeout counts
// Notes:   Bus lines resolved here from both open-drain sides
`timescale 1ns/1ps
module tb;
	localparam int         STC   = 200;
	localparam int         TMO   = 2000;
	localparam logic [7:0] EEP_W = 8'ha6;
	localparam logic [7:0] CTL_W = 8'hb6;
	localparam logic [7:0] ARA_R = 8'h19;
	logic        clk, reset_n, scl_lo, sda_lo, scl_oe, sda_oe;
	logic [3:0]  strap;
	logic        shut, warn, wp_off, rd_valid, resp_en;
	logic [15:0] status;
	logic [7:0]  rd_data, rx_byte, rx_index, wr_len, rd_index, wlen_r;
	logic        alert_out_n, rx_valid, wr_done, rd_req, reg_mode;
	logic [6:0]  ctl_addr;
	logic [7:0]  rx_r [0:3];
	int          st_cnt_r, st_max_r, err_total, comparisons;
	logic        sda_d_r, scl_d_r, scl_o, sda_o;
	wire         scl_w = !(scl_lo || scl_oe);
	wire         sda_w = !(sda_lo || sda_oe);
	psi_slave #(.STRETCH_CYC(STC), .TMO_CYC(TMO)) u_psi_slave (
		.clk(clk), .reset_n(reset_n), .scl_in(scl_w), .scl_out(scl_o), .scl_oe(scl_oe),
		.sda_in(sda_w), .sda_out(sda_o), .sda_oe(sda_oe), .addr_protocol_strap(strap),
		.shutdown_evt(shut), .warning_evt(warn), .status_word(status),
		.eeprom_wp_off(wp_off), .ctl_rd_valid(rd_valid), .ctl_rd_data(rd_data),
		.alert_out_n(alert_out_n), .ctl_rx_valid(rx_valid), .ctl_rx_byte(rx_byte),
		.ctl_rx_index(rx_index), .ctl_wr_done(wr_done), .ctl_wr_len(wr_len),
		.ctl_rd_req(rd_req), .ctl_rd_index(rd_index), .proto_reg_mode(reg_mode),
		.ctl_addr(ctl_addr)
	);
	psi_host_model #(.GAP_CYC(400)) u_psi_host_model (
		.clk(clk), .scl_w(scl_w), .sda_w(sda_w), .scl_lo(scl_lo), .sda_lo(sda_lo)
	);
	initial
	begin
		clk = 1'b0;
		forever #25 clk = !clk;
	end
	// Controller data source
	always @(negedge clk)
	begin
		rd_valid <= resp_en && rd_req;
		rd_data  <= 8'ha0 | rd_index;
	end
	always @(posedge clk)
	begin
		sda_d_r  <= sda_oe;
		scl_d_r  <= scl_w;
		st_cnt_r <= scl_oe ? st_cnt_r + 1 : 0;
		if (st_cnt_r > st_max_r)
			st_max_r <= st_cnt_r;
		if (rx_valid && rx_index < 8'h04)
			rx_r[rx_index[1:0]] <= rx_byte;
		if (wr_done)
			wlen_r <= wr_len;
		if (sda_oe && !sda_d_r && scl_w && scl_d_r)
			chk(16'h1, 16'h0);
	end
	task automatic hw(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic st();
		u_psi_host_model.hstart();
	endtask
	task automatic sp(input logic gap);
		u_psi_host_model.hstop(gap);
	endtask
	task automatic xw(input logic [7:0] d, input logic exp_ack);
		logic a;
		u_psi_host_model.wbyte(d, a);
		chk(16'(a), 16'(exp_ack));
	endtask
	task automatic rb(input logic ackit, output logic [7:0] d);
		u_psi_host_model.rbyte(ackit, d);
	endtask
	task automatic do_reset(input logic [3:0] code);
		strap = code;
		reset_n = 1'b0;
		hw(5);
		reset_n = 1'b1;
		hw(12);
	endtask
	task automatic ee_wr(input logic [7:0] loc, input logic [7:0] d);
		st();
		xw(EEP_W, 1'b1);
		xw(loc, 1'b1);
		xw(d, 1'b1);
		sp(1'b1);
	endtask
	task automatic t_strap();
		for (int c = 0; c < 8; c++)
		begin
			do_reset(4'(c));
			strap = 4'(c ^ 4);
			hw(10);
			chk(16'(reg_mode), 16'(c >= 4));
			chk(16'(ctl_addr), 16'(7'(7'h58 + c % 4)));
			st();
			xw({7'(7'h50 + c % 4), 1'b0}, 1'b1);
			sp(1'b0);
			if (c == 0)
			begin
				st();
				xw(8'hb0, 1'b1);
				xw(8'h01, 1'b1);
				sp(1'b0);
				chk(16'(wlen_r), 16'h1);
			end
		end
		do_reset(4'h8);
		chk(16'({reg_mode, ctl_addr}), 16'hdb);
		chk(16'({alert_out_n, scl_oe, sda_oe}), 16'h4);
		chk(16'({scl_o, sda_o}), 16'h0);
	endtask
	task automatic t_alert();
		for (int i = 0; i < 4; i++)
		begin
			{shut, warn} = 2'(i);
			hw(3);
			chk(16'(alert_out_n), 16'(i == 0));
		end
		{shut, warn} = 2'h0;
	endtask
	task automatic t_eeprom();
		logic [7:0] d;
		st();
		xw(8'ha0, 1'b0);
		sp(1'b0);
		wp_off = 1'b1;
		ee_wr(8'hff, 8'h3c);
		wp_off = 1'b0;
		ee_wr(8'hff, 8'h5a);
		st();
		xw(EEP_W, 1'b1);
		xw(8'hff, 1'b1);
		st();
		xw(EEP_W | 8'h01, 1'b1);
		rb(1'b0, d);
		sp(1'b0);
		chk(16'(d), 16'h3c);
	endtask
	task automatic t_ctl_wr();
		st();
		xw(CTL_W, 1'b1);
		xw(8'h21, 1'b1);
		xw(8'h34, 1'b1);
		xw(8'h12, 1'b1);
		sp(1'b0);
		chk({rx_r[0], rx_r[1]}, 16'h2134);
		chk({rx_r[2], wlen_r}, 16'h1203);
	endtask
	task automatic t_ctl_rd();
		logic [7:0] d0, d1, d2;
		resp_en = 1'b1;
		st();
		xw(CTL_W, 1'b1);
		xw(8'h05, 1'b1);
		st();
		xw(CTL_W | 8'h01, 1'b1);
		rb(1'b1, d0);
		rb(1'b1, d1);
		rb(1'b0, d2);
		sp(1'b0);
		chk({d0, d1}, 16'ha0a1);
		chk(16'(d2), 16'hff);
		resp_en = 1'b0;
	endtask
	task automatic t_stretch();
		logic [7:0] d;
		st();
		xw(CTL_W | 8'h01, 1'b1);
		rb(1'b0, d);
		sp(1'b0);
		chk(16'(d), 16'hff);
		chk(16'(st_max_r > STC / 2 && st_max_r <= STC + 2), 16'h1);
	endtask
	task automatic t_ara();
		logic [7:0] lo, hi;
		status = 16'hbeef;
		st();
		for (int i = 7; i > 3; i--) u_psi_host_model.wbit(EEP_W[i]);
		st();
		xw(ARA_R, 1'b1);
		rb(1'b1, lo);
		rb(1'b0, hi);
		sp(1'b0);
		chk({hi, lo}, 16'hbeef);
	endtask
	task automatic t_timeout();
		logic       b;
		logic [7:0] d;
		status = 16'h0000;
		st();
		xw(ARA_R, 1'b1);
		u_psi_host_model.rbit(b);
		chk(16'({b, sda_oe}), 16'h1);
		hw(TMO + TMO * 10 / 25);
		chk(16'({scl_oe, sda_oe}), 16'h0);
		status = 16'h00c3;
		st();
		xw(ARA_R, 1'b1);
		rb(1'b0, d);
		sp(1'b0);
		chk(16'(d), 16'hc3);
	endtask
	initial
	begin
		reset_n = 1'b0;
		strap = 4'h8;
		{shut, warn, wp_off, resp_en} = 4'h0;
		status = 16'h0000;
		{err_total, comparisons} = {2{32'sd0}};
		t_strap();
		t_alert();
		t_eeprom();
		t_ctl_wr();
		t_ctl_rd();
		t_stretch();
		t_ara();
		t_timeout();
		final_report();
	end
	initial
	begin
		repeat (98000) @(posedge clk);
		err_total++;
		final_report();
	end
endmodule
